// *** verilog/tcp_test_port.sv ***
// Test port: one-frame-late serial replay, frame marker, second marker, LEDs
// How it works
// - Line frame N-1 is stored, its server check latched, replayed in frame N.
// - Good frame: the 468 stored bits outside the two guards go out, fields in their order.
// - Good frame: both 22-bit turnaround guards are sent as zeros.
// - Failed check: the replayed frame is 512 ones instead.
// - Serial output never pauses; one bit every bit period, every frame.
// - Each bit spans two master clock cycles, or one when a frame start realigns the phase.
// - Frame marker rises with the first server preamble bit.
// - That rise comes one bit after the master clock edge that starts the frame.
// - Frame marker falls with the first client preamble bit.
// - LEDs: dark settling/free/hold, yellow fast, green locked/reference_loss_bridge_mode.
// - Optional second marker edge follows each GPS second boundary.
// - Six client modes come in; status outputs follow them.
`timescale 1ns/1ns
module tcp_test_port
#(
   parameter bit PPS_FITTED = 1'b1
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic master_clk_in,
   input wire logic line_data_in,
   input wire logic frame_start_in,
   input wire logic gps_second_in,
   input wire logic crc_check_done,
   input wire logic crc_check_good,
   input wire tcp_pkg::tcp_mode_t client_mode,
   output logic test_data_out,
   output logic frame_marker_out,
   output logic pulse_per_second_marker_out,
   output logic status_led_green,
   output logic status_led_yellow
);
   import tcp_pkg::*;

   logic rst_s1_reg;
   logic rst_sync_n;
   logic master_s1_reg;
   logic master_s2_reg;
   logic master_s3_reg;
   logic line_s1_reg;
   logic line_s2_reg;
   logic fstart_s1_reg;
   logic fstart_s2_reg;
   logic gps_s1_reg;
   logic gps_s2_reg;
   logic phase_reg;
   logic [BIT_IDX_W-1:0] bit_idx_reg;
   logic bank_reg;
   logic crc_seen_good_reg;
   logic replay_good_reg;
   logic master_rise;
   logic bit_start;
   logic frame_wrap;
   logic in_guard;
   logic [BIT_IDX_W:0] idx_wide;
   logic [BIT_IDX_W:0] g1_end;
   logic [BIT_IDX_W:0] g2_end;

   tcp_mem_if mif ();

   tcp_bit_mem #(.DEPTH(MEM_DEPTH)) i_tcp_bit_mem
   (
      .mclk(mclk),
      .mif(mif)
   );

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_sync_n <= rst_s1_reg;
      end
   end

   // Pin synchronisers; third master flop only for edge finding
   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         master_s1_reg <= 1'b0;
         master_s2_reg <= 1'b0;
         master_s3_reg <= 1'b0;
         line_s1_reg <= 1'b0;
         line_s2_reg <= 1'b0;
         fstart_s1_reg <= 1'b0;
         fstart_s2_reg <= 1'b0;
         gps_s1_reg <= 1'b0;
         gps_s2_reg <= 1'b0;
      end
      else
      begin
         master_s1_reg <= master_clk_in;
         master_s2_reg <= master_s1_reg;
         master_s3_reg <= master_s2_reg;
         line_s1_reg <= line_data_in;
         line_s2_reg <= line_s1_reg;
         fstart_s1_reg <= frame_start_in;
         fstart_s2_reg <= fstart_s1_reg;
         gps_s1_reg <= gps_second_in;
         gps_s2_reg <= gps_s1_reg;
      end
   end

   assign master_rise = master_s2_reg & ~master_s3_reg;
   // Frame start realigns the bit phase; otherwise every second edge
   assign bit_start = master_rise &
      (fstart_s2_reg | (phase_reg == PHASE_SECOND));
   // Counter free-runs if frame start is missing, so output never stops
   assign frame_wrap = bit_start &
      (fstart_s2_reg | (bit_idx_reg == LAST_BIT));

   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         phase_reg <= PHASE_SECOND;
      end
      else if (master_rise)
      begin
         phase_reg <= bit_start ? PHASE_FIRST : PHASE_SECOND;
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         bit_idx_reg <= LAST_BIT;
         bank_reg <= 1'b0;
      end
      else if (frame_wrap)
      begin
         bit_idx_reg <= '0;
         bank_reg <= ~bank_reg;
      end
      else if (bit_start)
      begin
         bit_idx_reg <= bit_idx_reg + 9'h001;
      end
   end

   // Line bit taken mid-bit, on the second master edge, away from changes
   assign mif.wr_en = master_rise & ~bit_start &
      (phase_reg == PHASE_FIRST);
   assign mif.wr_addr = {bank_reg, bit_idx_reg};
   assign mif.wr_data = line_s2_reg;
   // Other bank holds the previous frame at the same bit position
   assign mif.rd_addr = {~bank_reg, bit_idx_reg};

   // Check result; a result in the wrap cycle still counts
   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         crc_seen_good_reg <= 1'b0;
         replay_good_reg <= 1'b0;
      end
      else if (frame_wrap)
      begin
         replay_good_reg <= crc_check_done ? crc_check_good
                                           : crc_seen_good_reg;
         crc_seen_good_reg <= 1'b0;
      end
      else if (crc_check_done)
      begin
         crc_seen_good_reg <= crc_check_good;
      end
   end

   // One bit wider: the second guard ends at the frame end and would wrap
   assign idx_wide = {1'b0, bit_idx_reg};
   assign g1_end = {1'b0, FIRST_GUARD_START} + {1'b0, GUARD_LEN};
   assign g2_end = {1'b0, SECOND_GUARD_START} + {1'b0, GUARD_LEN};
   assign in_guard =
      ((idx_wide >= {1'b0, FIRST_GUARD_START}) && (idx_wide < g1_end)) ||
      ((idx_wide >= {1'b0, SECOND_GUARD_START}) && (idx_wide < g2_end));

   // Output lags the line by one bit, so the registered read has settled;
   // marker and data share that lag and stay aligned
   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         test_data_out <= SUBSTITUTE_BIT;
         frame_marker_out <= 1'b0;
      end
      else if (bit_start)
      begin
         if (!replay_good_reg)
         begin
            test_data_out <= SUBSTITUTE_BIT;
         end
         else if (in_guard)
         begin
            test_data_out <= GUARD_BIT;
         end
         else
         begin
            test_data_out <= mif.rd_data;
         end
         frame_marker_out <= (bit_idx_reg < CLIENT_PREAMBLE_START);
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         pulse_per_second_marker_out <= 1'b0;
      end
      else
      begin
         pulse_per_second_marker_out <= PPS_FITTED & gps_s2_reg;
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         status_led_green <= 1'b0;
         status_led_yellow <= 1'b0;
      end
      else
      begin
         case (client_mode)
            fast_acquisition_mode:
            begin
               status_led_green <= 1'b0;
               status_led_yellow <= 1'b1;
            end
            locked_mode, reference_loss_bridge_mode:
            begin
               status_led_green <= 1'b1;
               status_led_yellow <= 1'b0;
            end
            default:
            begin
               status_led_green <= 1'b0;
               status_led_yellow <= 1'b0;
            end
         endcase
      end
   end
endmodule

// *** include/tcp_pkg.sv ***
// Constants and types shared by the timing client test port
package tcp_pkg;
   localparam int FRAME_BITS = 512;
   localparam int BIT_IDX_W = 9;
   localparam int MEM_ADDR_W = BIT_IDX_W + 1;
   localparam int MEM_DEPTH = 2 * FRAME_BITS;
   localparam int GUARD_BITS = 22;
   localparam logic [BIT_IDX_W-1:0] LAST_BIT = 9'h1FF;
   localparam logic [BIT_IDX_W-1:0] FIRST_GUARD_START = 9'h0EA;
   localparam logic [BIT_IDX_W-1:0] CLIENT_PREAMBLE_START = 9'h100;
   localparam logic [BIT_IDX_W-1:0] SECOND_GUARD_START = 9'h1EA;
   localparam logic [BIT_IDX_W-1:0] GUARD_LEN = 9'h016;
   localparam int MASTER_PER_BIT = 2;
   localparam logic PHASE_FIRST = 1'b0;
   localparam logic PHASE_SECOND = 1'b1;
   localparam logic SUBSTITUTE_BIT = 1'b1;
   localparam logic GUARD_BIT = 1'b0;

   typedef enum logic [2:0]
   {
      oscillator_settling_mode = 3'b000,
      free_running_mode = 3'b001,
      fast_acquisition_mode = 3'b010,
      locked_mode = 3'b011,
      reference_loss_bridge_mode = 3'b100,
      last_frequency_hold_mode = 3'b101
   } tcp_mode_t;
endpackage

// *** include/tcp_mem_if.sv ***
// Port bundle between the frame buffer control and its bit memory
`timescale 1ns/1ns
interface tcp_mem_if;
   import tcp_pkg::*;
   logic wr_en;
   logic [MEM_ADDR_W-1:0] wr_addr;
   logic wr_data;
   logic [MEM_ADDR_W-1:0] rd_addr;
   logic rd_data;
   modport ctrl
   (
      output wr_en,
      output wr_addr,
      output wr_data,
      output rd_addr,
      input rd_data
   );
   modport mem
   (
      input wr_en,
      input wr_addr,
      input wr_data,
      input rd_addr,
      output rd_data
   );
endinterface

// *** verilog/tcp_bit_mem.sv ***
// Two-bank frame bit memory with registered read data
`timescale 1ns/1ns
module tcp_bit_mem
#(
   parameter int DEPTH = tcp_pkg::MEM_DEPTH
)
(
   input wire logic mclk,
   tcp_mem_if.mem mif
);
   import tcp_pkg::*;

   logic store_reg [DEPTH];

   always_ff @(posedge mclk)
   begin
      if (mif.wr_en)
      begin
         store_reg[mif.wr_addr] <= mif.wr_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      mif.rd_data <= store_reg[mif.rd_addr];
   end
endmodule

// *** verification/tcp_asserts.sv ***
// Concurrent checks on the test port outputs
`timescale 1ns/1ns
module tcp_asserts
#(
   parameter bit PPS_FITTED = 1'b1
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic gps_second_in,
   input wire tcp_pkg::tcp_mode_t client_mode,
   input wire logic test_data_out,
   input wire logic frame_marker_out,
   input wire logic pulse_per_second_marker_out,
   input wire logic status_led_green,
   input wire logic status_led_yellow
);
   import tcp_pkg::*;
   logic [2:0] up_cnt;
   logic [1:0] n_rise;
   logic [13:0] f_cnt;
   logic mk_d;
   // Skips the synced reset tail and pipeline fill
   wire live = up_cnt == 3'h7;
   wire mk_rise = frame_marker_out && !mk_d;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         up_cnt <= 3'h0;
         n_rise <= 2'h0;
         f_cnt <= 14'h0000;
         mk_d <= 1'b0;
      end
      else
      begin
         up_cnt <= live ? up_cnt : up_cnt + 3'h1;
         n_rise <= (mk_rise && n_rise != 2'h3) ? n_rise + 2'h1 : n_rise;
         f_cnt <= mk_rise ? 14'h0001 : f_cnt + 14'h0001;
         mk_d <= frame_marker_out;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Shortest legal bit is one master cycle at a frame realign
   sequence s_mk_hi;
      frame_marker_out [*6];
   endsequence
   AST_LED_GREEN: assert property (live |-> status_led_green ==
      ($past(client_mode) inside {locked_mode, reference_loss_bridge_mode}))
      else $error("green led wrong");
   AST_LED_YELLOW: assert property (live |-> status_led_yellow ==
      ($past(client_mode) == fast_acquisition_mode))
      else $error("yellow led wrong");
   AST_LED_EXCL: assert property
      (!(status_led_green && status_led_yellow)) else $error("both leds lit");
   AST_PPS: assert property (live |->
      pulse_per_second_marker_out == (PPS_FITTED && $past(gps_second_in, 3)))
      else $error("pps wrong");
   AST_BIT_HOLD: assert property (live && $changed(test_data_out)
      |=> $stable(test_data_out) [*6]) else $error("bit too short");
   AST_MK_HI: assert property ($rose(frame_marker_out) |=> s_mk_hi)
      else $error("marker high too short");
   AST_MK_LO: assert property ($fell(frame_marker_out) |=>
      !frame_marker_out [*6]) else $error("marker low too short");
   // 512 bits of 16 mclk each at the bench master rate
   AST_FRAME_PER: assert property (mk_rise && n_rise >= 2'h2
      |-> f_cnt == 14'h2000) else $error("frame period wrong");
endmodule
bind tcp_test_port tcp_asserts #(.PPS_FITTED(PPS_FITTED)) i_tcp_asserts
(
   .mclk, .rst_n, .gps_second_in, .client_mode, .test_data_out,
   .frame_marker_out, .pulse_per_second_marker_out,
   .status_led_green, .status_led_yellow
);

// *** verification/tcp_line_src.sv ***
// Line side model: master clock, frame start and bit index
`timescale 1ns/1ns
module tcp_line_src
(
   output logic master_clk_in,
   output logic frame_start_in,
   output int bit_idx
);
   logic ph = 1'b1;
   initial
   begin
      master_clk_in = 1'b0;
      frame_start_in = 1'b0;
      bit_idx = 511;
      #13;
      forever #200 master_clk_in = ~master_clk_in;
   end
   always @(posedge master_clk_in)
   begin
      ph <= ~ph;
      if (ph)
         bit_idx <= (bit_idx == 511) ? 0 : bit_idx + 1;
   end
   // High across the rise that opens bit 0
   always @(negedge master_clk_in)
      frame_start_in <= ph && bit_idx == 511;
endmodule

// *** verification/tcp_test_port_tb.sv ***
// Self-checking bench for the test port
`timescale 1ns/1ns
module tcp_test_port_tb;
   import tcp_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, line_data_in = 1'b0;
   logic gps_second_in = 1'b0, crc_check_done = 1'b0, crc_check_good = 1'b0;
   tcp_mode_t client_mode = oscillator_settling_mode;
   logic master_clk_in, frame_start_in, test_data_out, frame_marker_out;
   logic pulse_per_second_marker_out, status_led_green, status_led_yellow;
   int bit_idx, errors = 0, n_compared = 0;
   bit cur[512], prev[512], pg;
   bit good[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
   tcp_line_src i_tcp_line_src(.master_clk_in, .frame_start_in, .bit_idx);
   tcp_test_port i_tcp_test_port
   (
      .mclk, .rst_n, .master_clk_in, .line_data_in, .frame_start_in,
      .gps_second_in, .crc_check_done, .crc_check_good, .client_mode,
      .test_data_out, .frame_marker_out, .pulse_per_second_marker_out,
      .status_led_green, .status_led_yellow
   );
   initial
      forever #25 mclk = ~mclk;
   task automatic check(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_idx(input int k);
      int n;
      n = 0;
      while (bit_idx != k)
      begin
         @(negedge mclk);
         n++;
         if (n > 10000)
         begin
            errors++;
            end_sim();
         end
      end
   endtask
   initial
   begin
      bit e;
      void'($urandom(32'h70227A3C));
      repeat (16) @(negedge mclk);
      rst_n = 1'b1;
      // First line frame has no frame start, so it is skipped
      wait_idx(300);
      for (int f = 0; f < 5; f++)
      begin
         for (int k = 0; k < 512; k++)
         begin
            wait_idx(k);
            line_data_in = 1'($urandom_range(1, 0));
            cur[k] = line_data_in;
            gps_second_in = 1'($urandom_range(1, 0));
            client_mode = tcp_mode_t'($urandom_range(5, 0));
            // Two results per frame: the later one must decide
            crc_check_done = (k == 300 || k == 400);
            crc_check_good = (k == 400) ? good[f] : !good[f];
            @(negedge mclk);
            crc_check_done = 1'b0;
            repeat (10) @(negedge mclk);
            e = client_mode inside {locked_mode, reference_loss_bridge_mode};
            check(status_led_green, e);
            e = client_mode == fast_acquisition_mode;
            check(status_led_yellow, e);
            check(pulse_per_second_marker_out, gps_second_in);
            if (f > 0 && k > 0)
            begin
               e = !(k - 1 inside {[234:255], [490:511]}) && prev[k - 1];
               check(test_data_out, !pg || e);
               check(frame_marker_out, k <= 256);
            end
         end
         prev = cur;
         pg = good[f];
         $display("frame %0d done", f);
      end
      end_sim();
   end
endmodule
